// ---- core/uic_core.sv ----
// Purpose: interrupt flags, line format, line inversion, soft flow and baud measurement
// Assumes: sys_clk 10 MHz, rst async high, APB slave, shifter events on sys_clk
// Notes: zero-wait-state APB answer; pins synchronised by two flops
// Functional notes
// R1 - Gap-done event sets its raw flag
// R2 - Transmit-done event sets its raw flag
// R3 - RS485 echo parity/framing errors set flags
// R4 - RS485 clash event sets its flag
// R5 - Escape character match sets its flag
// R6 - Sleep edge count over threshold wakes
// R7 - Masked status is raw AND enable
// R8 - Clear register ones clear raw flags
// R9 - Parity select: zero even, one odd
// R10 - Length codes give 5 to 8 bits
// R11 - Stop codes give 1, 1.5, 2 bits
// R12 - Break after data, count resets ten
// R13 - Infrared eleventh bit copy or zero
// R14 - Infrared enable, start, loopback, inversions
// R15 - Loopback routes transmit to receiver
// R16 - Queue reset bits empty the FIFOs
// R17 - Per-line inversion of six signals
// R18 - Send pause char above pause threshold
// R19 - Send resume char below resume threshold
// R20 - Frame end when byte gap exceeds threshold
// R21 - Transmit idle gap length is configurable
// R22 - Record low, high pulse and edge count
// R23 - Zero after stop sets break flag
// R24 - Raw flags stick until cleared
// R25 - Interrupt when any masked bit set
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "uic_regs.svh"
module uic_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire uic_pkg::uic_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rxdPin,
  input wire logic ctsPin,
  input wire logic dsrPin,
  output logic txdPin,
  output logic rtsPin,
  output logic dtrPin,
  input wire logic txSerial,
  input wire logic rtsCore,
  input wire logic dtrCore,
  output logic rxSerial,
  output logic ctsLevel,
  output logic dsrLevel,
  input wire logic txGapDoneEvt,
  input wire logic txDoneEvt,
  input wire logic echoParityEvt,
  input wire logic echoFrameEvt,
  input wire logic clashEvt,
  input wire logic breakDetEvt,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic bitTick,
  input wire logic lightSleep,
  input wire logic [8:0] rxFifoCount,
  output logic parityOdd,
  output logic parityEnable,
  output logic [1:0] dataBits,
  output logic [1:0] stopBits,
  output logic sendBreakAfterData,
  output logic [7:0] breakBitCount,
  output logic [9:0] txIdleCount,
  output logic irEnable,
  output logic irTxEnable,
  output logic irBitElevenControl,
  output logic txFlowEnable,
  output logic rxQueueReset,
  output logic txQueueReset,
  output logic flowCharRequest,
  output logic [7:0] flowChar,
  output logic rxFrameEnd
);
  import uic_pkg::*;

  logic [31:0] raw;
  logic [31:0] ena;
  logic [`UIC_FMT_W-1:0] fmt;
  logic [16:0] pauseCfg;
  logic [16:0] resumeCfg;
  logic [27:0] idleCfg;
  logic [11:0] aux;
  logic [7:0] escChar;
  uic_pulse_t lowMin;
  uic_pulse_t highMin;
  uic_pulse_t lowCnt;
  uic_pulse_t highCnt;
  logic [9:0] edgeCnt;
  logic [9:0] wakeCnt;
  logic [9:0] gapCnt;
  logic frameOpen;
  logic [1:0] rxSync;
  logic [1:0] ctsSync;
  logic [1:0] dsrSync;
  logic rxPrev;
  logic rxLine;
  logic rxEdge;
  logic wrEn;
  logic [31:0] clrMask;
  logic [31:0] evt;
  logic [31:0] next_raw;
  logic [31:0] next_ena;
  logic [31:0] next_prdata;
  logic next_err;
  uic_flow_t flowState;

  function automatic uic_pulse_t minOf(input uic_pulse_t a, input uic_pulse_t b);
    minOf = (a < b) ? a : b;
  endfunction

  function automatic uic_pulse_t satInc(input uic_pulse_t a);
    satInc = (a == 12'hFFF) ? a : a + 12'h001;
  endfunction

  // APB: data prepared at setup, answered in the access phase
  assign wrEn = psel && penable && pready && pwrite;
  assign clrMask = (wrEn && paddr == `UIC_CLR_OFS) ? pwdata : 32'h00000000; // [R8]

  always_comb begin
    next_err = 1'b0;
    next_prdata = 32'h00000000;
    unique case (paddr)
      `UIC_RAW_OFS: next_prdata = raw;
      `UIC_MSK_OFS: next_prdata = raw & ena; // [R7]
      `UIC_ENA_OFS: next_prdata = ena;
      `UIC_CLR_OFS: next_prdata = 32'h00000000;
      `UIC_FMT_OFS: next_prdata = {7'h00, fmt};
      `UIC_LOW_OFS: next_prdata = {20'h00000, lowMin}; // [R22]
      `UIC_HIGH_OFS: next_prdata = {20'h00000, highMin}; // [R22]
      `UIC_EDGE_OFS: next_prdata = {22'h000000, edgeCnt}; // [R22]
      `UIC_PAUSE_OFS: next_prdata = {15'h0000, pauseCfg};
      `UIC_RESUME_OFS: next_prdata = {15'h0000, resumeCfg};
      `UIC_IDLE_OFS: next_prdata = {4'h0, idleCfg};
      `UIC_AUX_OFS: next_prdata = {20'h00000, aux};
      `UIC_ESC_OFS: next_prdata = {24'h000000, escChar};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      if (psel && !penable && !pwrite) begin
        prdata <= next_err ? 32'h00000000 : next_prdata;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ena <= 32'h00000000;
      fmt <= `UIC_FMT_RST;
      pauseCfg <= `UIC_PAUSE_RST; // [R18]
      resumeCfg <= `UIC_RESUME_RST; // [R19]
      idleCfg <= `UIC_IDLE_RST; // [R12] [R20]
      aux <= `UIC_AUX_RST;
      escChar <= `UIC_ESC_RST;
    end else if (wrEn) begin
      unique case (paddr)
        `UIC_ENA_OFS: ena <= pwdata & `UIC_FLAG_MASK; // [R7]
        `UIC_FMT_OFS: fmt <= pwdata[`UIC_FMT_W-1:0];
        `UIC_PAUSE_OFS: pauseCfg <= pwdata[16:0];
        `UIC_RESUME_OFS: resumeCfg <= pwdata[16:0];
        `UIC_IDLE_OFS: idleCfg <= pwdata[27:0];
        `UIC_AUX_OFS: aux <= pwdata[11:0];
        `UIC_ESC_OFS: escChar <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Format and mode outputs to the shifters
  assign parityOdd = fmt[`UIC_F_PAR]; // [R9]
  assign parityEnable = fmt[`UIC_F_PAREN]; // [R9]
  assign dataBits = fmt[`UIC_F_BITS]; // [R10]
  assign stopBits = fmt[`UIC_F_STOP]; // [R11]
  assign sendBreakAfterData = fmt[`UIC_F_BRK]; // [R12]
  assign breakBitCount = idleCfg[`UIC_BRKNUM]; // [R12]
  assign txIdleCount = idleCfg[`UIC_TXGAP]; // [R21]
  assign irEnable = fmt[`UIC_F_IREN]; // [R14]
  assign irTxEnable = fmt[`UIC_F_IRTXEN]; // [R14]
  assign irBitElevenControl = fmt[`UIC_F_IRWCTL]; // [R13]
  assign txFlowEnable = fmt[`UIC_F_TXFLOW];
  assign rxQueueReset = fmt[`UIC_F_RXRST]; // [R16]
  assign txQueueReset = fmt[`UIC_F_TXRST]; // [R16]

  // Pin synchronisers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxSync <= 2'b11;
      ctsSync <= 2'b11;
      dsrSync <= 2'b11;
    end else begin
      rxSync <= {rxSync[0], rxdPin};
      ctsSync <= {ctsSync[0], ctsPin};
      dsrSync <= {dsrSync[0], dsrPin};
    end
  end

  // Receive line after inversion and loopback selection
  always_comb begin
    if (fmt[`UIC_F_LOOP] || (fmt[`UIC_F_IREN] && fmt[`UIC_F_IRLOOP])) begin
      rxLine = txSerial; // [R15] [R14]
    end else begin
      rxLine = rxSync[1] ^ fmt[`UIC_F_RXINV] ^ (fmt[`UIC_F_IREN] & fmt[`UIC_F_IRRXINV]); // [R17]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txdPin <= 1'b1;
      rtsPin <= 1'b1;
      dtrPin <= 1'b1;
      rxSerial <= 1'b1;
      ctsLevel <= 1'b1;
      dsrLevel <= 1'b1;
    end else begin
      txdPin <= txSerial ^ fmt[`UIC_F_TXINV] ^ (fmt[`UIC_F_IREN] & fmt[`UIC_F_IRTXINV]); // [R17]
      rtsPin <= rtsCore ^ fmt[`UIC_F_RTSINV]; // [R17]
      dtrPin <= dtrCore ^ fmt[`UIC_F_DTRINV]; // [R17]
      rxSerial <= rxLine;
      ctsLevel <= ctsSync[1] ^ fmt[`UIC_F_CTSINV]; // [R17]
      dsrLevel <= dsrSync[1] ^ fmt[`UIC_F_DSRINV]; // [R17]
    end
  end

  // Baud measurement on the receive line
  assign rxEdge = rxLine ^ rxPrev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxPrev <= 1'b1;
      lowCnt <= 12'h000;
      highCnt <= 12'h000;
      lowMin <= 12'hFFF;
      highMin <= 12'hFFF;
      edgeCnt <= 10'h000;
    end else begin
      rxPrev <= rxLine;
      if (rxEdge && edgeCnt != 10'h3FF) begin
        edgeCnt <= edgeCnt + 10'h001; // [R22]
      end
      if (rxEdge && rxLine) begin
        lowMin <= minOf(lowMin, lowCnt); // [R22]
        lowCnt <= 12'h000;
      end else if (!rxLine) begin
        lowCnt <= satInc(lowCnt);
      end
      if (rxEdge && !rxLine) begin
        highMin <= minOf(highMin, highCnt); // [R22]
        highCnt <= 12'h000;
      end else if (rxLine) begin
        highCnt <= satInc(highCnt);
      end
    end
  end

  // Edge counting during light sleep
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wakeCnt <= 10'h000;
    end else if (!lightSleep) begin
      wakeCnt <= 10'h000;
    end else if (rxEdge && wakeCnt != 10'h3FF) begin
      wakeCnt <= wakeCnt + 10'h001;
    end
  end

  // Events; the set wins over a clear in the same cycle
  always_comb begin
    evt = 32'h00000000;
    evt[`UIC_BRK_BIT] = breakDetEvt; // [R23]
    evt[`UIC_GAP_BIT] = txGapDoneEvt; // [R1]
    evt[`UIC_TXDONE_BIT] = txDoneEvt; // [R2]
    evt[`UIC_EPAR_BIT] = aux[`UIC_AUX_485] && echoParityEvt; // [R3]
    evt[`UIC_EFRM_BIT] = aux[`UIC_AUX_485] && echoFrameEvt; // [R3]
    evt[`UIC_CLASH_BIT] = aux[`UIC_AUX_485] && clashEvt; // [R4]
    evt[`UIC_ESC_BIT] = rxCharValid && rxChar == escChar; // [R5]
    evt[`UIC_WAKE_BIT] = lightSleep && wakeCnt > aux[`UIC_AUX_ACT]; // [R6]
  end

  // Next raw flags and enables, so irq follows the masked status without lag
  assign next_raw = (raw & ~clrMask) | evt; // [R24] [R8]
  assign next_ena = (wrEn && paddr == `UIC_ENA_OFS) ? (pwdata & `UIC_FLAG_MASK) : ena; // [R7]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw <= 32'h00000000;
    end else begin
      raw <= next_raw; // [R24] [R8]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      // Enable writes act on irq in the same cycle as on the masked status
      irq <= |(next_raw & next_ena); // [R25]
    end
  end

  // End of frame from the receive gap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gapCnt <= 10'h000;
      frameOpen <= 1'b0;
      rxFrameEnd <= 1'b0;
    end else begin
      rxFrameEnd <= 1'b0;
      if (rxCharValid) begin
        gapCnt <= 10'h000;
        frameOpen <= 1'b1;
      end else if (frameOpen && bitTick) begin
        if (gapCnt >= idleCfg[`UIC_RXGAP]) begin
          rxFrameEnd <= 1'b1; // [R20]
          frameOpen <= 1'b0;
        end else begin
          gapCnt <= gapCnt + 10'h001;
        end
      end
    end
  end

  // Software flow control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flowState <= FLOW_RUN;
      flowCharRequest <= 1'b0;
      flowChar <= 8'h00;
    end else begin
      flowCharRequest <= 1'b0;
      if (!aux[`UIC_AUX_SWFC]) begin
        flowState <= FLOW_RUN;
      end else begin
        unique case (flowState)
          FLOW_RUN: begin
            if (rxFifoCount > pauseCfg[`UIC_THR]) begin
              flowCharRequest <= 1'b1; // [R18]
              flowChar <= pauseCfg[`UIC_CHR];
              flowState <= FLOW_PAUSED;
            end
          end
          FLOW_PAUSED: begin
            if (rxFifoCount < resumeCfg[`UIC_THR]) begin
              flowCharRequest <= 1'b1; // [R19]
              flowChar <= resumeCfg[`UIC_CHR];
              flowState <= FLOW_RUN;
            end
          end
        endcase
      end
    end
  end
endmodule // uic_core

// ---- core/uic_pkg.sv ----
// Purpose: shared types of the serial port control block
// Assumes: nothing
// Notes: offsets and values live in uic_regs.svh
package uic_pkg;
  typedef enum logic {FLOW_RUN, FLOW_PAUSED} uic_flow_t;
  typedef logic [11:0] uic_pulse_t;
  typedef logic [7:0] uic_addr_t;
endpackage

// ---- core/uic_regs.svh ----
// Purpose: register offsets, field positions and reset values of the serial port control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef UIC_REGS_SVH
`define UIC_REGS_SVH
`define UIC_RAW_OFS 8'h04
`define UIC_MSK_OFS 8'h08
`define UIC_ENA_OFS 8'h0C
`define UIC_CLR_OFS 8'h10
`define UIC_FMT_OFS 8'h20
`define UIC_LOW_OFS 8'h28
`define UIC_HIGH_OFS 8'h2C
`define UIC_EDGE_OFS 8'h30
`define UIC_PAUSE_OFS 8'h3C
`define UIC_RESUME_OFS 8'h40
`define UIC_IDLE_OFS 8'h44
`define UIC_AUX_OFS 8'h48
`define UIC_ESC_OFS 8'h58
// Raw flag positions
`define UIC_BRK_BIT 7
`define UIC_GAP_BIT 13
`define UIC_TXDONE_BIT 14
`define UIC_EPAR_BIT 15
`define UIC_EFRM_BIT 16
`define UIC_CLASH_BIT 17
`define UIC_ESC_BIT 18
`define UIC_WAKE_BIT 19
`define UIC_FLAG_MASK 32'h000FE080
// Format register fields
`define UIC_F_PAR 0
`define UIC_F_PAREN 1
`define UIC_F_BITS 3:2
`define UIC_F_STOP 5:4
`define UIC_F_BRK 8
`define UIC_F_IRLOOP 9
`define UIC_F_IRTXEN 10
`define UIC_F_IRWCTL 11
`define UIC_F_IRTXINV 12
`define UIC_F_IRRXINV 13
`define UIC_F_LOOP 14
`define UIC_F_TXFLOW 15
`define UIC_F_IREN 16
`define UIC_F_RXRST 17
`define UIC_F_TXRST 18
`define UIC_F_RXINV 19
`define UIC_F_CTSINV 20
`define UIC_F_DSRINV 21
`define UIC_F_TXINV 22
`define UIC_F_RTSINV 23
`define UIC_F_DTRINV 24
`define UIC_FMT_W 25
// Other fields
`define UIC_THR 8:0
`define UIC_CHR 16:9
`define UIC_RXGAP 9:0
`define UIC_TXGAP 19:10
`define UIC_BRKNUM 27:20
`define UIC_AUX_485 0
`define UIC_AUX_SWFC 1
`define UIC_AUX_ACT 11:2
// Reset values
`define UIC_FMT_RST 25'h000001C
`define UIC_PAUSE_RST 17'h026E0
`define UIC_RESUME_RST 17'h02200
`define UIC_IDLE_RST 28'hA40100
`define UIC_AUX_RST 12'h00C
`define UIC_ESC_RST 8'h2B
`endif

// ---- verification/tb.sv ----
// Purpose: self-checking bench of the serial port control block
// Assumes: APB master here, remote model on the receive line
// Notes: random format values from a fixed xorshift seed
`timescale 1ns/1ps
`include "uic_regs.svh"
module tb;
  import uic_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, lastErr, go = 0, busy;
  uic_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, r, s, seed = 32'h867F;
  logic pready, pslverr, irq, rxdPin, ctsPin = 1, dsrPin = 1, txdPin, rtsPin, dtrPin;
  logic txSerial = 1, rtsCore = 1, dtrCore = 1, rxSerial, ctsLevel, dsrLevel, bitTick = 0;
  logic lightSleep = 0, parityOdd, parityEnable, sendBreakAfterData, irEnable, irTxEnable;
  logic irBitElevenControl, txFlowEnable, rxQueueReset, txQueueReset, flowCharRequest;
  logic rxFrameEnd;
  logic [6:0] evt = 7'h0;
  logic [8:0] rxFifoCount = 9'h0;
  logic [3:0] pulses = 4'h3;
  logic [1:0] dataBits, stopBits;
  logic [7:0] rxChar = 8'h2B, breakBitCount, flowChar, fcCnt = 0, fcChr = 0, fe = 0;
  logic [9:0] txIdleCount;
  int err_count = 0, checked = 0, hit;
  int bitOf[7] = '{7, 13, 14, 15, 16, 17, 18};
  logic [7:0] rsA[9] = '{8'h04, 8'h08, 8'h0C, 8'h20, 8'h3C, 8'h40, 8'h44, 8'h28, 8'h30};
  logic [31:0] rsV[9] = '{0, 0, 0, 32'h1C, 32'h26E0, 32'h2200, 32'hA40100, 32'hFFF, 0};
  uic_core i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .rxdPin, .ctsPin, .dsrPin, .txdPin, .rtsPin, .dtrPin, .txSerial, .rtsCore,
    .dtrCore, .rxSerial, .ctsLevel, .dsrLevel, .breakDetEvt(evt[0]), .txGapDoneEvt(evt[1]),
    .txDoneEvt(evt[2]), .echoParityEvt(evt[3]), .echoFrameEvt(evt[4]), .clashEvt(evt[5]),
    .rxCharValid(evt[6]), .rxChar, .bitTick, .lightSleep, .rxFifoCount, .parityOdd,
    .parityEnable, .dataBits, .stopBits, .sendBreakAfterData, .breakBitCount, .txIdleCount,
    .irEnable, .irTxEnable, .irBitElevenControl, .txFlowEnable, .rxQueueReset, .txQueueReset,
    .flowCharRequest, .flowChar, .rxFrameEnd);
  uic_remote_model i_far (.sys_clk, .go, .pulses, .rxdPin, .busy);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (flowCharRequest) begin
      fcCnt <= fcCnt + 8'h1;
      fcChr <= flowChar;
    end
    if (rxFrameEnd) fe <= fe + 8'h1;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t no pready", $time);
      final_report();
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(0, a, 0);
    chk(q, e, w);
  endtask
  task automatic tick(input int i, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (i < 7) evt[i] <= 1;
      else bitTick <= 1;
      @(posedge sys_clk);
      evt <= 7'h0;
      bitTick <= 0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic burst(input logic [3:0] p);
    pulses <= p;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    repeat (2) @(posedge sys_clk);
    wait (busy === 1'b0);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #3000000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    foreach (rsA[i]) rd(rsA[i], rsV[i], "reset value");
    rd(8'h14, 0, "unmapped");
    chk(lastErr, 1, "slverr");
    apb(1, `UIC_RAW_OFS, 32'hFFFFFFFF);
    rd(`UIC_RAW_OFS, 0, "ro write");
    burst(3);
    rd(`UIC_EDGE_OFS, 6, "edges");
    apb(0, `UIC_LOW_OFS, 0);
    chk(q >= 6 && q <= 8, 1, "low pulse");
    apb(0, `UIC_HIGH_OFS, 0);
    chk(q >= 11 && q <= 13, 1, "high pulse");
    $display("autobaud done");
    tick(3, 1);
    tick(1, 1);
    rd(`UIC_RAW_OFS, 32'h2000, "refused echo");
    rd(`UIC_MSK_OFS, 0, "masked off");
    chk(irq, 0, "irq masked");
    apb(1, `UIC_CLR_OFS, 32'hFFFFFFFF);
    apb(1, `UIC_AUX_OFS, 32'h00D);
    apb(1, `UIC_ENA_OFS, 32'hFFFFFFFF);
    rd(`UIC_ENA_OFS, `UIC_FLAG_MASK, "enable");
    for (int i = 0; i < 7; i++) begin
      tick(i, 1);
      rd(`UIC_RAW_OFS, 32'h1 << bitOf[i], "raw");
      rd(`UIC_MSK_OFS, 32'h1 << bitOf[i], "masked");
      chk(irq, 1, "irq");
      apb(1, `UIC_CLR_OFS, ~(32'h1 << bitOf[i]));
      rd(`UIC_RAW_OFS, 32'h1 << bitOf[i], "clear zero");
      apb(1, `UIC_CLR_OFS, 32'h1 << bitOf[i]);
      rd(`UIC_RAW_OFS, 0, "clear one");
    end
    for (int p = 1; p < 4; p += 2) begin
      lightSleep <= 1;
      burst(p[3:0]);
      lightSleep <= 0;
      rd(`UIC_RAW_OFS, (2 * p > 3) << 19, "wake");
      apb(1, `UIC_CLR_OFS, 32'hFFFFFFFF);
    end
    $display("flags done");
    for (int i = 0; i < 16; i++) begin
      r = xs() & (i[0] ? 32'h1FFFFFF : 32'h1FE8DFF);
      r[5:2] = i[3:0];
      s = xs();
      {txSerial, rtsCore, dtrCore, ctsPin, dsrPin} <= s[4:0];
      apb(1, `UIC_FMT_OFS, r);
      rd(`UIC_FMT_OFS, r, "format");
      chk({parityOdd, parityEnable, dataBits, stopBits, sendBreakAfterData, irEnable,
        irTxEnable, irBitElevenControl, txFlowEnable, rxQueueReset, txQueueReset},
        {r[0], r[1], r[3:2], r[5:4], r[8], r[16], r[10], r[11], r[15], r[17], r[18]},
        "config");
      repeat (4) @(posedge sys_clk);
      if (!i[0]) chk({txdPin, rtsPin, dtrPin, rxSerial, ctsLevel, dsrLevel}, {s[4] ^ r[22],
        s[3] ^ r[23], s[2] ^ r[24], !r[19], s[1] ^ r[20], s[0] ^ r[21]}, "pins");
    end
    apb(1, `UIC_FMT_OFS, 32'h401C);
    txSerial <= 0;
    repeat (4) @(posedge sys_clk);
    chk(rxSerial, 0, "loopback");
    apb(1, `UIC_FMT_OFS, 32'h1C);
    $display("format done");
    apb(1, `UIC_AUX_OFS, 32'h00E);
    apb(1, `UIC_PAUSE_OFS, 32'hAA0A);
    apb(1, `UIC_RESUME_OFS, 32'h2204);
    foreach (rsV[i]) if (i < 4) begin
      rxFifoCount <= (i == 0) ? 9'd10 : (i == 1) ? 9'd11 : (i == 2) ? 9'd5 : 9'd3;
      repeat (6) @(posedge sys_clk);
      chk({fcCnt, fcChr}, {8'(i > 0) + 8'(i > 2), (i > 2) ? 8'h11 : (i > 0) ? 8'h55 : 8'h00},
        "flow");
    end
    r = (xs() & 32'hFFFFC00) | 32'h5;
    apb(1, `UIC_IDLE_OFS, r);
    @(posedge sys_clk);
    chk({breakBitCount, txIdleCount}, {r[27:20], r[19:10]}, "idle config");
    rxChar <= 8'h41;
    tick(6, 1);
    hit = 0;
    for (int k = 1; k < 9; k++) begin
      tick(7, 1);
      if (fe != 0 && hit == 0) hit = k;
    end
    chk({fe, 8'(hit)}, {8'h1, 8'h6}, "frame end");
    $display("stream done");
    final_report();
  end
endmodule // tb

// ---- verification/uic_core_assertions.sv ----
// Purpose: port checks of the serial port control block
// Assumes: one clock, rst async high
// Notes: shadows enable and format writes
`timescale 1ns/1ps
`include "uic_regs.svh"
module uic_core_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire uic_pkg::uic_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic irq,
  input wire logic txSerial,
  input wire logic txdPin,
  input wire logic txGapDoneEvt,
  input wire logic txDoneEvt,
  input wire logic echoParityEvt,
  input wire logic echoFrameEvt,
  input wire logic clashEvt,
  input wire logic breakDetEvt,
  input wire logic rxCharValid,
  input wire logic lightSleep,
  input wire logic parityOdd,
  input wire logic parityEnable,
  input wire logic [1:0] dataBits,
  input wire logic [1:0] stopBits,
  input wire logic flowCharRequest,
  input wire logic rxFrameEnd
);
  import uic_pkg::*;
  logic [31:0] enaSh;
  logic [24:0] fmtSh;
  wire wrAcc = psel & penable & pready & pwrite;
  wire quiet = !(txGapDoneEvt | txDoneEvt | breakDetEvt | echoParityEvt | echoFrameEvt
    | clashEvt | rxCharValid | lightSleep);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) enaSh <= 32'h0;
    else if (wrAcc && paddr == `UIC_ENA_OFS) enaSh <= pwdata & `UIC_FLAG_MASK;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) fmtSh <= `UIC_FMT_RST;
    else if (wrAcc && paddr == `UIC_FMT_OFS) fmtSh <= pwdata[24:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_clear_all;
    wrAcc && paddr == `UIC_CLR_OFS && pwdata == 32'hFFFFFFFF && quiet ##1 quiet;
  endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_clear; s_clear_all |=> !irq; endproperty
  property p_evt_irq;
    txGapDoneEvt && enaSh[13] || txDoneEvt && enaSh[14] || breakDetEvt && enaSh[7] |=> irq;
  endproperty
  property p_sticky; irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq; endproperty
  property p_masked; (enaSh == 32'h0) [*3] |-> !irq; endproperty
  property p_flow_pulse; flowCharRequest |=> !flowCharRequest; endproperty
  property p_frame_pulse; rxFrameEnd |=> !rxFrameEnd; endproperty
  property p_fmt;
    {parityOdd, parityEnable, dataBits, stopBits} == {fmtSh[0], fmtSh[1], fmtSh[3:2], fmtSh[5:4]};
  endproperty
  property p_txinv;
    txdPin == ($past(txSerial) ^ $past(fmtSh[22] ^ (fmtSh[16] & fmtSh[12])));
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_clear: assert property (p_clear) else $error("irq after clear");
  a_evt_irq: assert property (p_evt_irq) else $error("event missed");
  a_sticky: assert property (p_sticky) else $error("irq dropped");
  a_masked: assert property (p_masked) else $error("irq while masked");
  a_flow_pulse: assert property (p_flow_pulse) else $error("flow pulse long");
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse long");
  a_fmt: assert property (p_fmt) else $error("format outputs");
  a_txinv: assert property (p_txinv) else $error("tx level");
endmodule // uic_core_assertions
bind uic_core uic_core_assertions i_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .irq, .txSerial, .txdPin, .txGapDoneEvt, .txDoneEvt, .echoParityEvt,
  .echoFrameEvt, .clashEvt, .breakDetEvt, .rxCharValid, .lightSleep, .parityOdd,
  .parityEnable, .dataBits, .stopBits, .flowCharRequest, .rxFrameEnd);

// ---- verification/uic_remote_model.sv ----
// Purpose: remote serial device driving the receive line
// Assumes: line idles high
// Notes: sends a burst of low and high pulses on request
`timescale 1ns/1ps
module uic_remote_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [3:0] pulses,
  output logic rxdPin,
  output logic busy
);
  initial begin
    rxdPin = 1'b1;
    busy = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < pulses; i++) begin
        rxdPin <= 1'b0;
        repeat (7) @(posedge sys_clk);
        rxdPin <= 1'b1;
        repeat (12) @(posedge sys_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule // uic_remote_model
